// ### sim/dpll_switch_sva.sv
`timescale 1ns/100ps
module dpll_switch_sva #(
  parameter int NCH = 2,
  parameter int NPROF = 6,
  parameter int TW = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic [NCH*NPROF-1:0] prof_valid_i,
  input wire logic [NCH*2-1:0] loop_state_o,
  input wire logic [NCH-1:0] closed_loop_o,
  input wire logic [NCH*TW-1:0] tune_word_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire [1:0] ls0 = loop_state_o[1:0];
  wire mode0_wr = wr_i && addr_i == 16'h2105;
  ////////////////////////////////////////
  property p_closed; closed_loop_o[0] == !ls0[1]; endproperty
  a_closed: assert property (p_closed) else $error("closed flag off state");
  property p_tw_closed; !ls0[1] |-> tune_word_o[TW-1:0] == '0; endproperty
  a_tw_closed: assert property (p_tw_closed) else $error("tune word in closed loop");
  property p_switch_len; $rose(ls0 == 2'd1) |-> (ls0 == 2'd1) [*8] ##1 ls0 != 2'd1; endproperty
  a_switch_len: assert property (p_switch_len) else $error("switch length wrong");
  property p_force_hold; mode0_wr && wdata_i[1:0] == 2'b10 |-> ##[1:3] ls0 == 2'd2; endproperty
  a_force_hold: assert property (p_force_hold) else $error("holdover not forced");
  property p_force_free; mode0_wr && wdata_i[0] |-> ##[1:3] ls0 == 2'd3; endproperty
  a_force_free: assert property (p_force_free) else $error("freerun not forced");
  property p_free_wins; mode0_wr && wdata_i[1:0] == 2'b11 |-> ##[1:3] ls0 == 2'd3; endproperty
  a_free_wins: assert property (p_free_wins) else $error("holdover beat freerun");
  property p_free_ch1;
    wr_i && addr_i == 16'h2205 && wdata_i[0] |-> ##[1:3] loop_state_o[3:2] == 2'd3;
  endproperty
  a_free_ch1: assert property (p_free_ch1) else $error("ch1 freerun not forced");
  property p_no_ref; prof_valid_i[NPROF-1:0] == '0 [*8] |-> ##[0:9] ls0[1]; endproperty
  a_no_ref: assert property (p_no_ref) else $error("closed loop with no reference");
endmodule : dpll_switch_sva

bind dpll_reference_switch_control dpll_switch_sva #(.NCH(NCH), .NPROF(NPROF), .TW(TW)) u_sva (
  .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .prof_valid_i(prof_valid_i), .loop_state_o(loop_state_o), .closed_loop_o(closed_loop_o),
  .tune_word_o(tune_word_o)
);

// ### sim/ref_valid_model.sv
`timescale 1ns/100ps
// Reference inputs: slow mode models a monitor that needs cycles to qualify a source
module ref_valid_model #(
  parameter int W = 12
) (
  input wire logic clk_i,
  input wire logic [W-1:0] want_i,
  input wire logic slow_i,
  output logic [W-1:0] valid_o
);
  logic [W-1:0] d1_r, d2_r, d3_r, d4_r;
  always_ff @(posedge clk_i) begin
    d1_r <= want_i;
    d2_r <= d1_r;
    d3_r <= d2_r;
    d4_r <= d3_r;
  end
  assign valid_o = slow_i ? d4_r : want_i;
endmodule : ref_valid_model

// ### sim/tb.sv
`timescale 1ns/100ps
module tb;
  import dpll_switch_pkg::*;
  logic clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, slow = 0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic [11:0] want = 12'hFC7;
  logic [1:0] hist_ok_i = 2'b11;
  logic [15:0] hold_tw_i = 16'h00C3;
  wire [11:0] prof_valid;
  wire [7:0] rdata_o;
  wire [3:0] loop_state_o;
  wire [5:0] active_prof_o;
  wire [1:0] closed_loop_o;
  wire [15:0] tune_word_o;
  int error_cnt = 0, checks = 0, cyc = 0;

  ref_valid_model u_ref_valid_model (.clk_i(clk_i), .want_i(want), .slow_i(slow),
    .valid_o(prof_valid));
  dpll_reference_switch_control u_dpll_reference_switch_control (.clk_i(clk_i),
    .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .prof_valid_i(prof_valid), .hist_ok_i(hist_ok_i),
    .hold_tw_i(hold_tw_i), .loop_state_o(loop_state_o), .active_prof_o(active_prof_o),
    .closed_loop_o(closed_loop_o), .tune_word_o(tune_word_o));
  ////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rdata_o});
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt
  task automatic setv(input logic [2:0] v, input logic s, input int n);
    @(posedge clk_i);
    want[2:0] <= v;
    slow <= s;
    wt(n);
  endtask : setv
  task automatic st(input loop_state_e e);
    chk("state0", 16'(e), 16'(loop_state_o[1:0]));
  endtask : st
  task automatic pf(input logic [2:0] p);
    chk("prof0", 16'(p), 16'(active_prof_o[2:0]));
  endtask : pf
  ////////////////////////////////////////
  task automatic t_reset;
    wt(14);
    st(LOOP_LOCKED);
    chk("closed0", 16'h0001, 16'(closed_loop_o[0]));
    chk("closed1", 16'h0001, 16'(closed_loop_o[1]));
    chk("prof1", 16'h0000, 16'(active_prof_o[5:3]));
    rd(16'h2105, 8'h00);
    rd(16'h3011, 8'h80);
    rd(16'h200C, 8'h00);
    rd(16'h0000, 8'h00);
    wr(16'h200C, 8'hE0);
    rd(16'h3011, 8'h00);
  endtask : t_reset
  task automatic t_switch;
    wr(16'h1220, 8'h16);
    wr(16'h1240, 8'h06);
    rd(16'h1220, 8'h16);
    setv(3'b110, 1'b0, 14);
    pf(3'd2);
    rd(16'h3011, 8'h80);
    wr(16'h200C, 8'hE0);
    rd(16'h3011, 8'h00);
    setv(3'b111, 1'b0, 14);
    pf(3'd2);
    setv(3'b010, 1'b1, 20);
    st(LOOP_LOCKED);
    pf(3'd1);
    setv(3'b110, 1'b0, 14);
    pf(3'd2);
  endtask : t_switch
  task automatic t_force;
    wr(16'h2108, 8'h5A);
    rd(16'h2108, 8'h5A);
    wr(16'h200C, 8'hE0);
    wr(16'h2105, 8'h02);
    wt(3);
    st(LOOP_HOLD);
    chk("tw hold", 16'h00C3, 16'(tune_word_o[7:0]));
    rd(16'h3011, 8'h20);
    wr(16'h200C, 8'hE0);
    wr(16'h2105, 8'hFF);
    wt(3);
    st(LOOP_FREE);
    chk("tw free", 16'h005A, 16'(tune_word_o[7:0]));
    rd(16'h3011, 8'h40);
    rd(16'h2105, 8'h7F);
    wr(16'h2105, 8'h00);
    wt(14);
    st(LOOP_LOCKED);
    wr(16'h2208, 8'h3C);
    wr(16'h2205, 8'h01);
    wt(3);
    chk("state1", 16'h0003, 16'(loop_state_o[3:2]));
    chk("tw1 free", 16'h003C, 16'(tune_word_o[15:8]));
    chk("closed1 free", 16'h0000, 16'(closed_loop_o[1]));
    wr(16'h2205, 8'h00);
  endtask : t_force
  task automatic t_modes;
    @(posedge clk_i);
    hist_ok_i <= 2'b10;
    for (int m = 0; m < 4; m++) begin
      wr(16'h2105, {1'b0, 3'd7, 2'(m), 2'b00});
      wt(14);
      chk("mode state", (m > 1) ? 16'h0003 : 16'h0000, 16'(loop_state_o[1:0]));
    end
    wr(16'h2105, 8'h18);
    wt(14);
    st(LOOP_LOCKED);
    pf(3'd1);
    @(posedge clk_i);
    hist_ok_i <= 2'b11;
  endtask : t_modes
  task automatic t_loss;
    wr(16'h2105, 8'h00);
    wt(14);
    wr(16'h200C, 8'hE0);
    setv(3'b000, 1'b0, 12);
    st(LOOP_HOLD);
    rd(16'h3011, 8'h20);
  endtask : t_loss
  ////////////////////////////////////////
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_switch();
    t_force();
    t_modes();
    t_loss();
    close_out();
  end
endmodule : tb

// ### src/dpll_reference_switch_control.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`include "dpll_switch_consts.svh"
//
// Overview of operation
// R1: Reference-switch event flag sets while moving to a newly active profile.
// R2: Freerun-entered event flag sets when the loop enters freerun.
// R3: Holdover-entered event flag sets when the loop enters holdover.
// R4: Flags stay set until software writes one to the matching clear bit.
// R5: Force-holdover bit puts the channel in holdover regardless of references.
// R6: Force-freerun bit puts the channel in freerun with fixed frequency.
// R7: Freerun output uses only the programmed freerun tuning word.
// R8: Holdover runs open loop on the word from the history processor.
// R9: Freerun takes precedence over holdover.
// R10: Both forced modes override profile selection; mode used only when clear.
// R11: Two-bit selection mode field sits at D3:D2 of the mode register.
// R12: Mode 0 auto, 1 manual/priority, 2 manual/holdover, 3 manual only.
// R13: Normally the loop runs closed on the selected reference.
// R14: An invalid active reference triggers an automatic switch to another.
// R15: With no valid reference the channel goes to holdover or freerun.
// R16: Software should avoid the manual-only selection mode.
// R17: Manual/holdover mode: invalid choice goes to holdover, or freerun.
// R18: Manual/priority mode: invalid choice triggers priority search first.
// R19: Search picks the valid profile with the smallest 5-bit priority.
// R20: Revert to the old profile only if current priority is 8 or more worse.
// R21: Each flag sets on the rising edge of its condition and holds.
//
module dpll_reference_switch_control
  import dpll_switch_pkg::*;
#(
  parameter int NCH = 2,
  parameter int NPROF = 6,
  parameter int TW = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [NCH*NPROF-1:0] prof_valid_i,
  input wire logic [NCH-1:0] hist_ok_i,
  input wire logic [NCH*TW-1:0] hold_tw_i,
  output logic [NCH*2-1:0] loop_state_o,
  output logic [NCH*3-1:0] active_prof_o,
  output logic [NCH-1:0] closed_loop_o,
  output logic [NCH*TW-1:0] tune_word_o
);

  ////////////////////////////////////////////////////////////////////
  // Address map per channel

  localparam logic [15:0] CLR_OFS [2] = '{`EVT_CLR0_OFS, `EVT_CLR1_OFS};
  localparam logic [15:0] MODE_OFS [2] = '{`MODE_CTL0_OFS, `MODE_CTL1_OFS};
  localparam logic [15:0] FTW_OFS [2] = '{`FREE_TW0_OFS, `FREE_TW1_OFS};
  localparam logic [15:0] STAT_OFS [2] = '{`EVT_STAT0_OFS, `EVT_STAT1_OFS};
  localparam logic [15:0] PRIO_BASE [2] = '{`PRIO0_BASE_OFS, `PRIO1_BASE_OFS};
  localparam logic [3:0] SW_CYC = 4'(`SWITCH_CYCLES);
  localparam int PW = `PRIO_MSB - `PRIO_LSB + 1;

  function automatic logic prio_at(
    input logic [15:0] addr,
    input logic [15:0] base,
    input int prof
  );
    logic [15:0] ofs;
    ofs = base + 16'(prof * `PRIO_STRIDE);
    return addr == ofs;
  endfunction : prio_at

  function automatic logic prof_ok(
    input logic [NPROF-1:0] valid,
    input logic [2:0] idx
  );
    logic ok;
    ok = 1'b0;
    for (int p = 0; p < NPROF; p++) begin
      if (idx == 3'(p)) begin
        ok = valid[p];
      end
    end
    return ok;
  endfunction : prof_ok

  ////////////////////////////////////////////////////////////////////
  // Read-back collection

  logic [7:0] ch_rd [NCH];
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;

  always_comb begin
    rdata_nxt = 8'h00;
    for (int c = 0; c < NCH; c++) begin
      rdata_nxt = rdata_nxt | ch_rd[c];
    end
  end

  // Read data stand for one cycle only; unmapped reads give zero
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rd_i ? rdata_nxt : 8'h00;
    end
  end

  assign rdata_o = rdata_r;

  ////////////////////////////////////////////////////////////////////
  // Channels

  for (genvar c = 0; c < NCH; c++) begin : g_ch

    logic [6:0] mode_r;
    logic [TW-1:0] ftw_r;
    logic [PW-1:0] prio_r [NPROF];
    logic [NPROF*PW-1:0] prio_flat;
    loop_state_e st_r;
    loop_state_e st_nxt;
    logic [2:0] cur_r;
    logic [2:0] prev_r;
    logic prev_ok_r;
    logic [3:0] sw_cnt_r;
    logic [2:0] evt_r;
    logic [2:0] evt_set;
    logic [TW-1:0] tw_r;
    logic [2:0] tgt;
    logic tgt_ok;
    logic srch_found;
    logic [2:0] srch_idx;
    logic [PW:0] prio_cur;
    logic [PW:0] prio_prev;

    wire [NPROF-1:0] pv = prof_valid_i[c*NPROF +: NPROF];
    wire frc_free = mode_r[`MODE_FREE_BIT];
    wire frc_hold = mode_r[`MODE_HOLD_BIT];
    wire sel_mode_e sel = sel_mode_e'(mode_r[`MODE_SEL_MSB:`MODE_SEL_LSB]); // [R11]
    wire [2:0] man_idx = mode_r[`MODE_MAN_MSB:`MODE_MAN_LSB];
    wire man_ok = prof_ok(pv, man_idx);
    wire in_loop = (st_r == LOOP_LOCKED) || (st_r == LOOP_SWITCH);
    wire cur_ok = in_loop && prof_ok(pv, cur_r);
    wire loop_state_e open_st = hist_ok_i[c] ? LOOP_HOLD : LOOP_FREE; // [R15] [R17]

    wire wr_mode = wr_i && (addr_i == MODE_OFS[c]);
    wire wr_ftw = wr_i && (addr_i == FTW_OFS[c]);
    wire wr_clr = wr_i && (addr_i == CLR_OFS[c]);
    wire rd_mode = addr_i == MODE_OFS[c];
    wire rd_ftw = addr_i == FTW_OFS[c];
    wire rd_stat = addr_i == STAT_OFS[c];

    wire [2:0] evt_clr = wr_clr ?
      {wdata_i[`EVT_SWITCH_BIT], wdata_i[`EVT_FREE_BIT], wdata_i[`EVT_HOLD_BIT]} : 3'h0;

    //////////////////////////////////////////////////////////////////
    // Priority registers

    for (genvar p = 0; p < NPROF; p++) begin : g_prio
      wire hit = prio_at(addr_i, PRIO_BASE[c], p);

      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          prio_r[p] <= `PRIO_RST;
        end else if (wr_i && hit) begin
          prio_r[p] <= wdata_i[`PRIO_MSB:`PRIO_LSB];
        end
      end

      assign prio_flat[p*PW +: PW] = prio_r[p];
    end

    logic [7:0] prio_rd;

    always_comb begin
      prio_rd = 8'h00;
      for (int p = 0; p < NPROF; p++) begin
        if (prio_at(addr_i, PRIO_BASE[c], p)) begin
          prio_rd = 8'({prio_r[p], 1'b0});
        end
      end
    end

    assign ch_rd[c] =
      rd_mode ? {1'b0, mode_r} :
      rd_ftw ? 8'(ftw_r) :
      rd_stat ? {evt_r, 5'h00} :
      prio_rd;

    //////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        mode_r <= `MODE_RST;
      end else if (wr_mode) begin
        mode_r <= wdata_i[6:0];
      end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        ftw_r <= TW'(`FREE_TW_RST);
      end else if (wr_ftw) begin
        ftw_r <= TW'(wdata_i);
      end
    end

    //////////////////////////////////////////////////////////////////
    // Profile selection

    profile_priority_search #(
      .NPROF(NPROF),
      .PW(PW)
    ) u_search (
      .valid_i(pv),
      .prio_i(prio_flat),
      .found_o(srch_found),
      .idx_o(srch_idx)
    ); // [R19]

    always_comb begin
      prio_cur = '0;
      prio_prev = '0;
      for (int p = 0; p < NPROF; p++) begin
        if (cur_r == 3'(p)) begin
          prio_cur = {1'b0, prio_r[p]};
        end
        if (prev_r == 3'(p)) begin
          prio_prev = {1'b0, prio_r[p]};
        end
      end
    end

    wire revert = prev_ok_r && prof_ok(pv, prev_r) && (prev_r != cur_r) &&
      (prio_cur >= prio_prev + `REVERT_GAP); // [R20]

    always_comb begin
      tgt = cur_r;
      tgt_ok = 1'b0;
      unique case (sel) // [R12]
        SEL_AUTO: begin
          if (cur_ok) begin
            tgt_ok = 1'b1;
            tgt = revert ? prev_r : cur_r; // [R20]
          end else if (srch_found) begin
            tgt_ok = 1'b1;
            tgt = srch_idx; // [R14]
          end
        end
        SEL_MAN_PRIO: begin
          if (man_ok) begin
            tgt_ok = 1'b1;
            tgt = man_idx;
          end else if (srch_found) begin
            tgt_ok = 1'b1;
            tgt = srch_idx; // [R18]
          end
        end
        SEL_MAN_HOLD, SEL_MAN_ONLY: begin
          if (man_ok) begin
            tgt_ok = 1'b1;
            tgt = man_idx; // [R17]
          end
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////
    // Loop state

    wire sw_done = sw_cnt_r == 4'h0;

    always_comb begin
      if (frc_free) begin
        st_nxt = LOOP_FREE; // [R6] [R9]
      end else if (frc_hold) begin
        st_nxt = LOOP_HOLD; // [R5] [R10]
      end else if (!tgt_ok) begin
        st_nxt = open_st; // [R15]
      end else if (in_loop && tgt == cur_r) begin
        st_nxt = (st_r == LOOP_SWITCH && !sw_done) ? LOOP_SWITCH : LOOP_LOCKED; // [R13]
      end else begin
        st_nxt = LOOP_SWITCH; // [R14]
      end
    end

    wire new_prof = (st_nxt == LOOP_SWITCH) && !(in_loop && tgt == cur_r);

    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        st_r <= LOOP_HOLD;
      end else begin
        st_r <= st_nxt;
      end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        cur_r <= 3'h0;
        prev_r <= 3'h0;
        prev_ok_r <= 1'b0;
      end else if (new_prof) begin
        cur_r <= tgt;
        prev_r <= cur_r;
        prev_ok_r <= in_loop;
      end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        sw_cnt_r <= 4'h0;
      end else if (new_prof) begin
        sw_cnt_r <= SW_CYC - 4'h1;
      end else if (!sw_done) begin
        sw_cnt_r <= sw_cnt_r - 4'h1;
      end
    end

    //////////////////////////////////////////////////////////////////
    // Tuning word

    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        tw_r <= '0;
      end else if (st_nxt == LOOP_FREE) begin
        tw_r <= ftw_r; // [R7]
      end else if (st_nxt == LOOP_HOLD) begin
        tw_r <= hold_tw_i[c*TW +: TW]; // [R8]
      end else begin
        tw_r <= '0;
      end
    end

    //////////////////////////////////////////////////////////////////
    // Event flags

    assign evt_set[2] = (st_nxt == LOOP_SWITCH) && new_prof; // [R1] [R21]
    assign evt_set[1] = (st_nxt == LOOP_FREE) && (st_r != LOOP_FREE); // [R2] [R21]
    assign evt_set[0] = (st_nxt == LOOP_HOLD) && (st_r != LOOP_HOLD); // [R3] [R21]

    // Set beats a clear in the same cycle
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        evt_r <= 3'h0;
      end else begin
        evt_r <= (evt_r & ~evt_clr) | evt_set; // [R4]
      end
    end

    //////////////////////////////////////////////////////////////////
    // Outputs

    logic closed_r;
    logic [2:0] act_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        closed_r <= 1'b0;
        act_r <= 3'h0;
      end else begin
        closed_r <= (st_nxt == LOOP_LOCKED) || (st_nxt == LOOP_SWITCH); // [R13]
        act_r <= new_prof ? tgt : cur_r;
      end
    end

    assign loop_state_o[c*2 +: 2] = st_r;
    assign active_prof_o[c*3 +: 3] = act_r;
    assign closed_loop_o[c] = closed_r;
    assign tune_word_o[c*TW +: TW] = tw_r;

  end

endmodule : dpll_reference_switch_control

// ### src/dpll_switch_consts.svh
`ifndef DPLL_SWITCH_CONSTS_SVH
`define DPLL_SWITCH_CONSTS_SVH

// Register offsets, one per channel
`define EVT_CLR0_OFS 16'h200C
`define EVT_CLR1_OFS 16'h2011
`define MODE_CTL0_OFS 16'h2105
`define MODE_CTL1_OFS 16'h2205
`define FREE_TW0_OFS 16'h2108
`define FREE_TW1_OFS 16'h2208
`define EVT_STAT0_OFS 16'h3011
`define EVT_STAT1_OFS 16'h3016
`define PRIO0_BASE_OFS 16'h1200
`define PRIO1_BASE_OFS 16'h1600
`define PRIO_STRIDE 16'h0020

// Mode control fields
`define MODE_FREE_BIT 0
`define MODE_HOLD_BIT 1
`define MODE_SEL_LSB 2
`define MODE_SEL_MSB 3
`define MODE_MAN_LSB 4
`define MODE_MAN_MSB 6
`define MODE_RST 7'h00

// Priority field
`define PRIO_LSB 1
`define PRIO_MSB 5
`define PRIO_RST 5'h00
`define REVERT_GAP 6'h08

// Event bits in status and clear registers
`define EVT_SWITCH_BIT 7
`define EVT_FREE_BIT 6
`define EVT_HOLD_BIT 5

// Other reset values
`define FREE_TW_RST 8'h00

// Timing
`define CLK_PERIOD_NS 8
`define SWITCH_TIME_NS 64
`define SWITCH_CYCLES ((`SWITCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### src/dpll_switch_pkg.sv
package dpll_switch_pkg;

  typedef enum logic [1:0] {
    LOOP_LOCKED,
    LOOP_SWITCH,
    LOOP_HOLD,
    LOOP_FREE
  } loop_state_e;

  typedef enum logic [1:0] {
    SEL_AUTO,
    SEL_MAN_PRIO,
    SEL_MAN_HOLD,
    SEL_MAN_ONLY
  } sel_mode_e;

endpackage : dpll_switch_pkg

// ### src/profile_priority_search.sv
`timescale 1ns/100ps
// Finds the valid profile with the smallest priority value
module profile_priority_search #(
  parameter int NPROF = 6,
  parameter int PW = 5
) (
  input wire logic [NPROF-1:0] valid_i,
  input wire logic [NPROF*PW-1:0] prio_i,
  output logic found_o,
  output logic [2:0] idx_o
);

  logic [PW-1:0] best;

  always_comb begin
    found_o = 1'b0;
    idx_o = 3'h0;
    best = '1;
    for (int p = 0; p < NPROF; p++) begin
      // Strictly lower wins, so ties go to the lower profile index
      if (valid_i[p] && (!found_o || prio_i[p*PW +: PW] < best)) begin
        found_o = 1'b1;
        idx_o = 3'(p);
        best = prio_i[p*PW +: PW];
      end
    end
  end

endmodule : profile_priority_search
